// ---- rtl/phytp_defs.svh ----
`ifndef PHYTP_DEFS_SVH
`define PHYTP_DEFS_SVH

// clock periods in ns
`define PHYTP_SYS_PERIOD_NS 10
`define PHYTP_PCLK_PERIOD_NS 160

// pin to action path: two synchroniser stages plus one edge register
`define PHYTP_PIN_LAT_CYC 3
`define PHYTP_PIN_LAT_NS (`PHYTP_PIN_LAT_CYC * `PHYTP_SYS_PERIOD_NS)

// register byte offsets
`define PHYTP_OFS_SLEEP_EXIT 8'h00
`define PHYTP_OFS_RADIO_WARMUP 8'h04
`define PHYTP_OFS_OCTET_LEAD 8'h08
`define PHYTP_OFS_TX_START_LAT 8'h0c
`define PHYTP_OFS_RX_START_LAT 8'h10
`define PHYTP_OFS_SEND_LISTEN_GAP 8'h14
`define PHYTP_OFS_LISTEN_SEND_GAP 8'h18
`define PHYTP_OFS_SYNC_LAT 8'h1c
`define PHYTP_OFS_SEND_SETUP 8'h20
`define PHYTP_OFS_LISTEN_SETUP 8'h24
`define PHYTP_OFS_SEND_HOLD 8'h28
`define PHYTP_OFS_LISTEN_HOLD 8'h2c
`define PHYTP_OFS_DEVICE_ID 8'h30
`define PHYTP_OFS_RELEASE_LAT 8'h34
`define PHYTP_OFS_STATUS 8'h38
`define PHYTP_OFS_PREAMBLE_LEN 8'h3c

// reset value of the writable preamble length, in link clock cycles
`define PHYTP_PREAMBLE_LEN_RST 16'h0018

// axi responses
`define PHYTP_RESP_OKAY 2'h0
`define PHYTP_RESP_SLVERR 2'h2
`define PHYTP_RESP_DECERR 2'h3

// synchroniser lanes
`define PHYTP_LANE_TXEN 0
`define PHYTP_LANE_RXEN 1
`define PHYTP_LANE_PCLK 2
`define PHYTP_LANE_SYNC 3
`define PHYTP_LANE_FEND 4

// status bit positions
`define PHYTP_STAT_TX_RUN 0
`define PHYTP_STAT_RX_ACQ 1
`define PHYTP_STAT_ACTIVE 2
`define PHYTP_STAT_DATA_REQ 3

`endif

// ---- rtl/phytp_pkg.sv ----
package phytp_pkg;

	typedef logic [1:0] phytp_resp_type;

	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] s3;
		logic [15:0] pcnt;
		logic tx_run;
		logic rx_acq;
		logic data_req;
		logic active;
		logic aw_have;
		logic w_have;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		phytp_resp_type bresp;
		logic rvalid;
		phytp_resp_type rresp;
		logic [31:0] rdata;
		logic [15:0] preamble_len;
	} phytp_state_type;

endpackage : phytp_pkg

// ---- rtl/phytp_param_set.sv ----
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "phytp_defs.svh"

module phytp_param_set #(
	parameter logic [15:0] SLEEP_EXIT_HALF_US = 16'h0190,
	parameter logic [15:0] RADIO_WARMUP_HALF_US = 16'h0028,
	parameter logic [7:0] OCTET_LEAD_US = 8'h01,
	parameter logic [15:0] SEND_LISTEN_GAP_NS = 16'h0064,
	parameter logic [15:0] LISTEN_SEND_GAP_NS = 16'h0064,
	parameter logic [15:0] SEND_SETUP_CYC = 16'h0002,
	parameter logic [15:0] LISTEN_SETUP_CYC = 16'h0002,
	parameter logic [15:0] SEND_HOLD_CYC = 16'h0002,
	parameter logic [15:0] LISTEN_HOLD_CYC = 16'h0002,
	parameter logic [15:0] DEVICE_ID = 16'h5a01 // arbitrary value
) (
	input wire logic clk_sys_i, // system clock
	input wire logic rst_n_i, // synchronous reset
	input wire logic pclk_i, // link clock, sampled
	input wire logic tx_en_i, // transmit enable from controller
	input wire logic rx_en_i, // receive enable from controller
	input wire logic sync_end_i, // sync sequence end seen by radio
	input wire logic frame_end_i, // received frame end seen by radio
	output logic tx_wave_o, // preamble waveform running
	output logic rx_acq_o, // preamble acquisition running
	output logic data_req_o, // first octet request
	output logic activity_indicator_o, // frame activity
	input wire logic [7:0] s_axi_awaddr_i, // write address
	input wire logic s_axi_awvalid_i, // write address valid
	output logic s_axi_awready_o, // write address ready
	input wire logic [31:0] s_axi_wdata_i, // write data
	input wire logic [3:0] s_axi_wstrb_i, // write strobes
	input wire logic s_axi_wvalid_i, // write data valid
	output logic s_axi_wready_o, // write data ready
	output logic [1:0] s_axi_bresp_o, // write response
	output logic s_axi_bvalid_o, // write response valid
	input wire logic s_axi_bready_i, // write response ready
	input wire logic [7:0] s_axi_araddr_i, // read address
	input wire logic s_axi_arvalid_i, // read address valid
	output logic s_axi_arready_o, // read address ready
	output logic [31:0] s_axi_rdata_o, // read data
	output logic [1:0] s_axi_rresp_o, // read response
	output logic s_axi_rvalid_o, // read response valid
	input wire logic s_axi_rready_i // read response ready
);

	localparam logic [15:0] PIN_LAT_NS = 16'(`PHYTP_PIN_LAT_NS);
	// lead rounded down to whole link cycles: a request that comes a little late is
	// harmless, one that comes before the promised lead is not
	localparam int LEAD_PCLK_INT = (int'(OCTET_LEAD_US) * 1000) / `PHYTP_PCLK_PERIOD_NS;
	localparam logic [16:0] LEAD_PCLK = 17'(LEAD_PCLK_INT);

	phytp_pkg::phytp_state_type state_reg;
	phytp_pkg::phytp_state_type state_next;
	logic [4:0] rise;
	logic [4:0] fall;
	logic [3:0] status;

	// static parameter table plus status and preamble length
	function automatic logic [33:0] rd_lookup(input logic [7:0] a, input logic [3:0] st,
			input logic [15:0] plen);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		rd_lookup = {`PHYTP_RESP_OKAY, 32'h0000_0000};
		unique case (w)
			`PHYTP_OFS_SLEEP_EXIT: rd_lookup[15:0] = SLEEP_EXIT_HALF_US;
			`PHYTP_OFS_RADIO_WARMUP: rd_lookup[15:0] = RADIO_WARMUP_HALF_US;
			`PHYTP_OFS_OCTET_LEAD: rd_lookup[7:0] = OCTET_LEAD_US;
			`PHYTP_OFS_TX_START_LAT: rd_lookup[15:0] = PIN_LAT_NS;
			`PHYTP_OFS_RX_START_LAT: rd_lookup[15:0] = PIN_LAT_NS;
			`PHYTP_OFS_SEND_LISTEN_GAP: rd_lookup[15:0] = SEND_LISTEN_GAP_NS;
			`PHYTP_OFS_LISTEN_SEND_GAP: rd_lookup[15:0] = LISTEN_SEND_GAP_NS;
			`PHYTP_OFS_SYNC_LAT: rd_lookup[15:0] = PIN_LAT_NS;
			`PHYTP_OFS_SEND_SETUP: rd_lookup[15:0] = SEND_SETUP_CYC;
			`PHYTP_OFS_LISTEN_SETUP: rd_lookup[15:0] = LISTEN_SETUP_CYC;
			`PHYTP_OFS_SEND_HOLD: rd_lookup[15:0] = SEND_HOLD_CYC;
			`PHYTP_OFS_LISTEN_HOLD: rd_lookup[15:0] = LISTEN_HOLD_CYC;
			`PHYTP_OFS_DEVICE_ID: rd_lookup[15:0] = DEVICE_ID;
			`PHYTP_OFS_RELEASE_LAT: rd_lookup[15:0] = PIN_LAT_NS;
			`PHYTP_OFS_STATUS: rd_lookup[3:0] = st;
			`PHYTP_OFS_PREAMBLE_LEN: rd_lookup[15:0] = plen;
			default: rd_lookup[33:32] = `PHYTP_RESP_DECERR;
		endcase
	endfunction : rd_lookup

	// only the preamble length is writable; the static table refuses writes
	function automatic phytp_pkg::phytp_resp_type wr_resp(input logic [7:0] a);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		if (w == `PHYTP_OFS_PREAMBLE_LEN) begin
			wr_resp = `PHYTP_RESP_OKAY;
		end else if (w < `PHYTP_OFS_STATUS) begin
			wr_resp = `PHYTP_RESP_SLVERR;
		end else if (w == `PHYTP_OFS_STATUS) begin
			wr_resp = `PHYTP_RESP_SLVERR;
		end else begin
			wr_resp = `PHYTP_RESP_DECERR;
		end
	endfunction : wr_resp

	assign rise = state_reg.s2 & ~state_reg.s3;
	assign fall = ~state_reg.s2 & state_reg.s3;
	assign status = {state_reg.data_req, state_reg.active, state_reg.rx_acq, state_reg.tx_run};

	assign tx_wave_o = state_reg.tx_run;
	assign rx_acq_o = state_reg.rx_acq;
	assign data_req_o = state_reg.data_req;
	assign activity_indicator_o = state_reg.active;
	assign s_axi_awready_o = !state_reg.aw_have && !state_reg.bvalid;
	assign s_axi_wready_o = !state_reg.w_have && !state_reg.bvalid;
	assign s_axi_bvalid_o = state_reg.bvalid;
	assign s_axi_bresp_o = state_reg.bresp;
	assign s_axi_arready_o = !state_reg.rvalid;
	assign s_axi_rvalid_o = state_reg.rvalid;
	assign s_axi_rresp_o = state_reg.rresp;
	assign s_axi_rdata_o = state_reg.rdata;

	always_comb begin
		state_next = state_reg;
		state_next.s1 = {frame_end_i, sync_end_i, pclk_i, rx_en_i, tx_en_i};
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;

		// transmit side: preamble counted in link clock edges
		if (rise[`PHYTP_LANE_TXEN]) begin
			state_next.tx_run = 1'b1;
			state_next.pcnt = 16'h0000;
			state_next.data_req = 1'b0;
			state_next.active = 1'b0;
		end else if (fall[`PHYTP_LANE_TXEN]) begin
			state_next.tx_run = 1'b0;
			state_next.pcnt = 16'h0000;
			state_next.data_req = 1'b0;
			state_next.active = 1'b0;
		end else if (state_reg.tx_run) begin
			if (rise[`PHYTP_LANE_PCLK] && state_reg.pcnt != 16'hffff) begin
				state_next.pcnt = state_reg.pcnt + 16'h0001;
			end
			if (({1'b0, state_reg.pcnt} + LEAD_PCLK) >= {1'b0, state_reg.preamble_len}) begin
				state_next.data_req = 1'b1;
			end
			if (state_reg.pcnt >= state_reg.preamble_len) begin
				state_next.active = 1'b1;
			end
		end

		// receive side
		if (rise[`PHYTP_LANE_RXEN]) begin
			state_next.rx_acq = 1'b1;
		end else if (fall[`PHYTP_LANE_RXEN]) begin
			state_next.rx_acq = 1'b0;
			state_next.active = 1'b0;
		end else if (state_reg.rx_acq) begin
			if (rise[`PHYTP_LANE_FEND]) begin
				state_next.active = 1'b0;
			end else if (rise[`PHYTP_LANE_SYNC]) begin
				state_next.active = 1'b1;
			end
		end

		// axi write: address and data in either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			state_next.aw_have = 1'b1;
			state_next.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			state_next.w_have = 1'b1;
			state_next.wdata = s_axi_wdata_i;
			state_next.wstrb = s_axi_wstrb_i;
		end
		if (state_reg.aw_have && state_reg.w_have) begin
			state_next.aw_have = 1'b0;
			state_next.w_have = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = wr_resp(state_reg.awaddr);
			if (wr_resp(state_reg.awaddr) == `PHYTP_RESP_OKAY) begin
				if (state_reg.wstrb[0]) begin
					state_next.preamble_len[7:0] = state_reg.wdata[7:0];
				end
				if (state_reg.wstrb[1]) begin
					state_next.preamble_len[15:8] = state_reg.wdata[15:8];
				end
			end
		end else if (state_reg.bvalid && s_axi_bready_i) begin
			state_next.bvalid = 1'b0;
		end

		// axi read: answer one cycle after the address is taken
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			state_next.rvalid = 1'b1;
			{state_next.rresp, state_next.rdata} =
				rd_lookup(s_axi_araddr_i, status, state_reg.preamble_len);
		end else if (state_reg.rvalid && s_axi_rready_i) begin
			state_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_reg <= '0;
			state_reg.preamble_len <= `PHYTP_PREAMBLE_LEN_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	default clocking chk_cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_sleep_exit_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_SLEEP_EXIT
		|=> s_axi_rvalid_o && s_axi_rdata_o == {16'h0000, SLEEP_EXIT_HALF_US})
		else $error("sleep exit time read wrong");

	chk_warmup_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_RADIO_WARMUP
		|=> s_axi_rvalid_o && s_axi_rdata_o == {16'h0000, RADIO_WARMUP_HALF_US})
		else $error("radio warmup time read wrong");

	chk_octet_request_lead: assert property (
		$rose(data_req_o) |->
			({1'b0, state_reg.pcnt} + LEAD_PCLK) >= {1'b0, state_reg.preamble_len})
		else $error("octet request raised too early");

	chk_tx_start_latency: assert property (
		$rose(tx_en_i) ##1 tx_en_i [*2] |-> !$past(tx_wave_o, 2) ##1 tx_wave_o)
		else $error("preamble start not three cycles after transmit enable");

	chk_rx_start_latency: assert property (
		$rose(rx_en_i) ##1 rx_en_i [*2] |-> ##1 rx_acq_o)
		else $error("acquisition start not three cycles after receive enable");

	chk_sync_activity: assert property (
		rx_acq_o && rx_en_i && !tx_wave_o && !frame_end_i && $rose(sync_end_i)
		##1 (sync_end_i && rx_en_i && !frame_end_i) [*2] |-> ##1 activity_indicator_o)
		else $error("activity not raised after sync end");

	chk_id_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_DEVICE_ID
		|=> s_axi_rresp_o == `PHYTP_RESP_OKAY && s_axi_rdata_o[15:0] == DEVICE_ID)
		else $error("identifier read wrong");

	chk_frame_end_release: assert property (
		rx_acq_o && rx_en_i && !tx_wave_o && $rose(frame_end_i)
		##1 (frame_end_i && rx_en_i) [*2] |-> ##1 !activity_indicator_o)
		else $error("activity not released after frame end");

	chk_static_write_refused: assert property (
		state_reg.aw_have && state_reg.w_have && state_reg.awaddr < `PHYTP_OFS_STATUS
		|=> s_axi_bvalid_o && s_axi_bresp_o == `PHYTP_RESP_SLVERR)
		else $error("static parameter write not refused");

	chk_release_lat_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_RELEASE_LAT
		|=> s_axi_rdata_o == {16'h0000, PIN_LAT_NS})
		else $error("release latency read wrong");

	// reported figures come back exactly as the constants behind them
	chk_lead_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_OCTET_LEAD
		|=> s_axi_rdata_o == {24'h00_0000, OCTET_LEAD_US})
		else $error("octet request lead read wrong");

	chk_tx_lat_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_TX_START_LAT
		|=> s_axi_rdata_o == {16'h0000, PIN_LAT_NS})
		else $error("transmit start latency read wrong");

	chk_rx_lat_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_RX_START_LAT
		|=> s_axi_rdata_o == {16'h0000, PIN_LAT_NS})
		else $error("receive start latency read wrong");

	chk_sync_lat_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_SYNC_LAT
		|=> s_axi_rdata_o == {16'h0000, PIN_LAT_NS})
		else $error("sync detect latency read wrong");

	chk_setup_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_SEND_SETUP
		|=> s_axi_rdata_o == {16'h0000, SEND_SETUP_CYC})
		else $error("send setup count read wrong");

	chk_hold_value: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `PHYTP_OFS_SEND_HOLD
		|=> s_axi_rdata_o == {16'h0000, SEND_HOLD_CYC})
		else $error("send hold count read wrong");

	chk_unmapped_read: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i >= 8'h40
		|=> s_axi_rresp_o == `PHYTP_RESP_DECERR && s_axi_rdata_o == 32'h0000_0000)
		else $error("unmapped read not refused");

	// a refused write must leave the only writable word alone as well
	chk_write_no_change: assert property (
		state_reg.aw_have && state_reg.w_have
		&& {state_reg.awaddr[7:2], 2'b00} != `PHYTP_OFS_PREAMBLE_LEN
		|=> $stable(state_reg.preamble_len))
		else $error("refused write changed state");

	chk_tx_clear: assert property (
		$fell(tx_en_i) ##1 (!tx_en_i) [*2] |-> ##1 !tx_wave_o && !data_req_o)
		else $error("transmit not stopped after enable fell");

	chk_rx_clear: assert property (
		$fell(rx_en_i) ##1 (!rx_en_i) [*2] |-> ##1 !rx_acq_o && !activity_indicator_o)
		else $error("acquisition not stopped after enable fell");

	chk_request_before_end: assert property (
		$rose(activity_indicator_o) && tx_wave_o && !rx_acq_o |-> data_req_o)
		else $error("preamble ended before the octet request");

	chk_request_in_tx: assert property (
		data_req_o |-> tx_wave_o)
		else $error("octet request outside transmission");

	chk_read_answer: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read not answered in one cycle");

	cov_octet_request: cover property ($rose(data_req_o));
	cov_rx_frame: cover property ($rose(activity_indicator_o) && rx_acq_o);
	cov_tx_frame: cover property ($rose(activity_indicator_o) && tx_wave_o);
	cov_write_refused: cover property (s_axi_bvalid_o && s_axi_bresp_o == `PHYTP_RESP_SLVERR);
	cov_preamble_write: cover property (s_axi_bvalid_o && s_axi_bresp_o == `PHYTP_RESP_OKAY);

endmodule : phytp_param_set

// ---- dv/phytp_mac_model.sv ----
`timescale 1ns/10ps

module phytp_mac_model #(
	parameter int GAP_NS = 100,
	parameter int SETUP_CYC = 2,
	parameter int HOLD_CYC = 2
) (
	input wire logic clk_sys_i, // system clock
	input wire logic activity_i, // activity indicator from device
	output logic tx_en_o, // transmit enable
	output logic rx_en_o, // receive enable
	output logic pclk_o // link clock, runs only while tx_en_o or rx_en_o is high
);
	realtime act_fall_t = 0.0;
	realtime rx_fall_t = 0.0;
	realtime tx_rise_t = 0.0;
	realtime rx_rise_t = 0.0;

	initial begin
		tx_en_o = 1'b0;
		rx_en_o = 1'b0;
		pclk_o = 1'b0;
		#37;
		forever begin
			#80;
			pclk_o = (tx_en_o || rx_en_o) ? ~pclk_o : 1'b0;
		end
	end

	always @(negedge activity_i) begin
		act_fall_t = $realtime;
	end

	task automatic send_start;
		while ($realtime - rx_fall_t < GAP_NS) @(posedge clk_sys_i);
		#(SETUP_CYC * 160);
		@(posedge clk_sys_i);
		tx_en_o <= 1'b1;
		tx_rise_t = $realtime;
	endtask : send_start

	task automatic send_stop;
		while ($realtime - tx_rise_t < HOLD_CYC * 160) @(posedge clk_sys_i);
		@(posedge clk_sys_i);
		tx_en_o <= 1'b0;
	endtask : send_stop

	task automatic listen_start;
		while ($realtime - act_fall_t < GAP_NS) @(posedge clk_sys_i);
		#(SETUP_CYC * 160);
		@(posedge clk_sys_i);
		rx_en_o <= 1'b1;
		rx_rise_t = $realtime;
	endtask : listen_start

	task automatic listen_stop;
		while ($realtime - rx_rise_t < HOLD_CYC * 160 ||
			$realtime - act_fall_t < HOLD_CYC * 160) @(posedge clk_sys_i);
		@(posedge clk_sys_i);
		rx_en_o <= 1'b0;
		rx_fall_t = $realtime;
	endtask : listen_stop
endmodule : phytp_mac_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`include "phytp_defs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 4000) begin @(negedge clk_sys); n++; end \
	if (!(c)) err_total++; end

module testbench;
	localparam logic [15:0] DEV_ID = 16'h3c7e; // arbitrary value
	logic clk_sys, rst_n, sync_end, frame_end, tx_wave, rx_acq, data_req, act;
	logic tx_en, rx_en, pclk, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int err_total = 0;
	int tests_run = 0;
	logic [15:0] exp_ro [14] = '{16'h0190, 16'h0028, 16'h0001, 16'h001e, 16'h001e, 16'h0064,
		16'h0064, 16'h001e, 16'h0002, 16'h0002, 16'h0002, 16'h0002, DEV_ID, 16'h001e};

	phytp_param_set #(.DEVICE_ID(DEV_ID)) dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
		.pclk_i(pclk), .tx_en_i(tx_en), .rx_en_i(rx_en), .sync_end_i(sync_end),
		.frame_end_i(frame_end), .tx_wave_o(tx_wave), .rx_acq_o(rx_acq),
		.data_req_o(data_req), .activity_indicator_o(act), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));

	phytp_mac_model mac (.clk_sys_i(clk_sys), .activity_i(act), .tx_en_o(tx_en),
		.rx_en_o(rx_en), .pclk_o(pclk));

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic ra, rw, aw_d, w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ra = awready;
			rw = wready;
			@(posedge clk_sys);
			if (ra) awvalid <= 1'b0;
			if (rw) wvalid <= 1'b0;
			aw_d = aw_d || ra;
			w_d = w_d || rw;
		end while (!(aw_d && w_d));
		do begin
			@(negedge clk_sys);
			ra = bvalid;
			r = bresp;
			@(posedge clk_sys);
		end while (!ra);
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ok;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ok = arready;
			@(posedge clk_sys);
		end while (!ok);
		arvalid <= 1'b0;
		do begin
			@(negedge clk_sys);
			ok = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
		end while (!ok);
		rready <= 1'b0;
	endtask : axi_rd

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 14; i++) begin
			axi_rd(8'(i * 4), d, r);
			`CHK(d, {16'h0000, exp_ro[i]})
			`CHK(r, `PHYTP_RESP_OKAY)
		end
		axi_wr(`PHYTP_OFS_SLEEP_EXIT, 32'hffff_ffff, 4'hf, r);
		`CHK(r, `PHYTP_RESP_SLVERR)
		axi_wr(`PHYTP_OFS_DEVICE_ID, 32'h0000_0000, 4'h3, r);
		`CHK(r, `PHYTP_RESP_SLVERR)
		axi_rd(`PHYTP_OFS_SLEEP_EXIT, d, r);
		`CHK(d, 32'h0000_0190)
		axi_rd(`PHYTP_OFS_DEVICE_ID, d, r);
		`CHK(d, {16'h0000, DEV_ID})
		axi_rd(8'h40, d, r);
		`CHK(r, `PHYTP_RESP_DECERR)
		axi_rd(`PHYTP_OFS_PREAMBLE_LEN, d, r);
		`CHK(d, 32'h0000_0018)
	endtask : t_regs

	task automatic t_send;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		realtime t_req;
		axi_wr(`PHYTP_OFS_PREAMBLE_LEN, 32'h0000_0020, 4'h3, r);
		`CHK(r, `PHYTP_RESP_OKAY)
		mac.send_start();
		`WAITC(tx_wave)
		`CHK(n <= 4, 1'b1)
		`WAITC(data_req)
		t_req = $realtime;
		`WAITC(act)
		`CHK(($realtime - t_req) <= 1000.0 && ($realtime - t_req) > 0.0, 1'b1)
		axi_rd(`PHYTP_OFS_STATUS, d, r);
		`CHK(d[3:0], 4'hd)
		mac.send_stop();
		`WAITC(!act && !tx_wave && !data_req)
		`CHK(n <= 4, 1'b1)
	endtask : t_send

	task automatic t_listen;
		int n;
		mac.listen_start();
		`WAITC(rx_acq)
		`CHK(n <= 4, 1'b1)
		@(posedge clk_sys);
		sync_end <= 1'b1;
		`WAITC(act)
		`CHK(n <= 4, 1'b1)
		@(posedge clk_sys);
		sync_end <= 1'b0;
		frame_end <= 1'b1;
		`WAITC(!act)
		`CHK(n <= 4, 1'b1)
		@(posedge clk_sys);
		frame_end <= 1'b0;
		mac.listen_stop();
		mac.send_start();
		`WAITC(tx_wave)
		`CHK(n <= 4, 1'b1)
		mac.send_stop();
	endtask : t_listen

	task automatic finish_test;
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		#200000;
		err_total++;
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		sync_end = 1'b0;
		frame_end = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs();
		t_send();
		t_listen();
		finish_test();
	end
endmodule : testbench
